/* File: core/bf_ms_tick.sv */
// Millisecond enable pulse divider
`timescale 1ns/1ps
module bf_ms_tick
	import bf_pkg::*;
#(
	parameter int DIV = MS_CYCLES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Tick
	output logic tick_o
);
	if (DIV < 2) begin : g_bad_div
		$error("bf_ms_tick: DIV must be at least 2");
	end

	logic [31:0] cnt_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= 32'h0000_0000;
		end else if (cnt_r == 32'(DIV - 1)) begin
			cnt_r <= 32'h0000_0000;
		end else begin
			cnt_r <= cnt_r + 32'h0000_0001;
		end
	end

	assign tick_o = (cnt_r == 32'(DIV - 1));
endmodule : bf_ms_tick

/* File: core/bf_pkg.sv */
// Package: register map, field layout, reset values and timing for the breaker failure stage
package bf_pkg;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_COND_SEL = 8'h04;
	localparam logic [7:0] REG_RELEASE = 8'h08;
	localparam logic [7:0] REG_DELAY = 8'h0C;
	localparam logic [7:0] REG_PH_ZC = 8'h10;
	localparam logic [7:0] REG_EF_ZC = 8'h14;
	localparam logic [7:0] REG_STATUS = 8'h18;
	localparam logic [7:0] REG_IRQ_STAT = 8'h1C;
	localparam logic [7:0] REG_IRQ_MASK = 8'h20;
	localparam logic [7:0] REG_START_CNT = 8'h24;
	localparam logic [7:0] REG_TRIP_CNT = 8'h28;
	localparam logic [7:0] REG_EF_SRC = 8'h2C;

	// Control register fields
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_EV_START_ON = 1;
	localparam int CTRL_EV_START_OFF = 2;
	localparam int CTRL_EV_TRIP_ON = 3;
	localparam int CTRL_EV_TRIP_OFF = 4;
	localparam int CTRL_CLR_START = 8;
	localparam int CTRL_CLR_TRIP = 9;

	// Release register: one byte per condition selector
	localparam int REL_MON = 0;
	localparam int REL_CB = 1;
	localparam int REL_ZC = 2;
	localparam int REL_BYTE = 8;

	// Status register fields
	localparam int STAT_START = 0;
	localparam int STAT_TRIP = 1;
	localparam int STAT_BLOCK = 2;

	// Event bits in status and mask
	localparam int EV_START_ON = 0;
	localparam int EV_START_OFF = 1;
	localparam int EV_TRIP_ON = 2;
	localparam int EV_TRIP_OFF = 3;
	localparam int EV_W = 4;

	// Condition selector count and per selector width
	localparam int NUM_COND = 4;
	localparam int SRC_W = 32;

	// Delay limits in milliseconds and ms tick
	localparam int DELAY_MIN_MS = 40;
	localparam int DELAY_MAX_MS = 200;
	localparam int CLK_HZ = 125_000_000;
	localparam int MS_CYCLES = CLK_HZ / 1000;

	// Zero current limits; phase in 0.01 x In, earth fault in 0.001 pu
	localparam logic [15:0] PH_ZC_MIN = 16'h0005;
	localparam logic [15:0] PH_ZC_MAX = 16'h0014;
	localparam logic [15:0] EF_ZC_STEP_MIN_STD = 16'h0005;
	localparam logic [15:0] EF_ZC_MIN_CORE = 16'h0032;
	localparam logic [15:0] EF_ZC_MAX_STD = 16'h1F40;
	localparam logic [15:0] EF_ZC_MAX_CALC = 16'h4E20;

	// Earth fault residual source codes
	localparam logic [1:0] EF_SRC_STD = 2'h0;
	localparam logic [1:0] EF_SRC_CORE = 2'h1;
	localparam logic [1:0] EF_SRC_CALC = 2'h2;

	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] RELEASE_RST = 32'h0000_0000;
	localparam logic [7:0] DELAY_RST = 8'h64;
	localparam logic [15:0] PH_ZC_RST = 16'h000A;
	localparam logic [15:0] EF_ZC_RST = 16'h0032;
	localparam logic [15:0] CNT_W16_ZERO = 16'h0000;
endpackage : bf_pkg

/* File: core/breaker_failure_stage.sv */
// Breaker failure supervision stage with Wishbone register slave
// Notes on behaviour
// - Each selector has its own release criteria
// - No criteria selected: release on stage dropout
// - Several criteria: release only when all true
// - Selector three releases by breaker or dropout
// - Selector three takes voltage, power, frequency starts
// - Selector four takes contacts and input signals
// - Timer starts when selected start becomes active
// - Delay expired: trip out and event logged
// - Operate delay settable 40 to 200 ms
// - Zero current needs every phase below threshold
// - Phase threshold 0.05 to 0.2 nominal
// - Earth threshold 0.001 steps, range by source
// - Start and trip counters, separately clearable
// - Starts only while enabled and start persists
// - Block pauses timer, forces start and trip outputs inactive
// - Four events each individually enabled
// - Zero current release only selectors one, two
//
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module breaker_failure_stage
	import bf_pkg::*;
#(
	parameter int MS_DIV = MS_CYCLES,
	parameter int CNT_W = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Start sources: 0 phase, 1 earth, 2 voltage/power/freq, 3 contacts/inputs
	input wire logic [SRC_W-1:0] start_src_i [NUM_COND],
	// Breaker open status, one per selector
	input wire logic [NUM_COND-1:0] cb_open_i,
	// Phase and earth fault currents in the threshold units
	input wire logic [15:0] phase_cur_i [3],
	input wire logic [15:0] ef_cur_i,
	// Block from the block matrix
	input wire logic block_i,
	// Outputs toward the output matrix
	output logic start_o,
	output logic trip_o,
	output logic irq_o
);
	if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt_w
		$error("breaker_failure_stage: CNT_W out of range");
	end

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [31:0] ctrl;
		logic [SRC_W*NUM_COND-1:0] cond_sel;
		logic [31:0] release_cfg;
		logic [7:0] delay_ms;
		logic [15:0] ph_zc;
		logic [15:0] ef_zc;
		logic [1:0] ef_src;
		logic [EV_W-1:0] irq_stat;
		logic [EV_W-1:0] irq_mask;
		logic [CNT_W-1:0] start_cnt;
		logic [CNT_W-1:0] trip_cnt;
		logic started;
		logic tripped;
		logic [7:0] elapsed_ms;
		logic ack;
		logic [31:0] rdata;
	} state_t;

	state_t st_r;
	state_t st_nxt;
	logic ms_tick;

	bf_ms_tick #(
		.DIV(MS_DIV)
	) u_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_o(ms_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// Per selector start and release terms
	logic [NUM_COND-1:0] cond_active;
	logic [NUM_COND-1:0] cond_release;
	logic zero_cur;

	// Every phase and the residual must sit below their pick-up
	assign zero_cur = (phase_cur_i[0] < st_r.ph_zc) && (phase_cur_i[1] < st_r.ph_zc)
		&& (phase_cur_i[2] < st_r.ph_zc) && (ef_cur_i < st_r.ef_zc);

	for (genvar g = 0; g < NUM_COND; g++) begin : g_cond
			logic [7:0] rel;
			logic use_zc;
			logic use_cb;
			logic use_mon;
			assign rel = st_r.release_cfg[g*REL_BYTE +: REL_BYTE];
			// Zero current exists only on the first two selectors
			assign use_zc = (g < 2) ? rel[REL_ZC] : 1'b0;
			// Selector four releases only on its monitored signals
			assign use_cb = (g == 3) ? 1'b0 : rel[REL_CB];
			// Fall back to dropout when nothing else is chosen; selector four always drops out
			assign use_mon = rel[REL_MON] || !(use_zc || use_cb);
			// Selector three and four source lists are their own inputs
			assign cond_active[g] = |(start_src_i[g] & st_r.cond_sel[g*SRC_W +: SRC_W]);
			// All enabled criteria must hold together
			assign cond_release[g] = (!use_mon || !cond_active[g])
				&& (!use_cb || cb_open_i[g]) && (!use_zc || zero_cur);
	end

	logic any_start;
	logic do_release;
	logic [NUM_COND-1:0] rel_sel;
	logic sel_any;

	assign any_start = |cond_active;
	// Selectors in use: those with a start source chosen
	always_comb begin
		for (int i = 0; i < NUM_COND; i++) begin
			rel_sel[i] = |st_r.cond_sel[i*SRC_W +: SRC_W];
		end
	end
	assign sel_any = |rel_sel;
	assign do_release = sel_any && &(cond_release | ~rel_sel);

	////////////////////////////////////////////////////////////////////////
	// Register write helper with byte enables
	function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction : wmask

	// Clamp the delay into its legal range
	function automatic logic [7:0] clamp_delay(input logic [7:0] d);
		if (d < 8'(DELAY_MIN_MS)) begin
			return 8'(DELAY_MIN_MS);
		end else if (d > 8'(DELAY_MAX_MS)) begin
			return 8'(DELAY_MAX_MS);
		end
		return d;
	endfunction : clamp_delay

	// Clamp a threshold between limits
	function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
			input logic [15:0] hi);
		if (v < lo) begin
			return lo;
		end else if (v > hi) begin
			return hi;
		end
		return v;
	endfunction : clamp16

	////////////////////////////////////////////////////////////////////////
	logic req;
	logic wr;
	logic [31:0] w;
	logic [15:0] ef_lo;
	logic [15:0] ef_hi;
	logic [EV_W-1:0] ev;
	logic [EV_W-1:0] ev_clr;
	logic timer_done;

	assign req = cyc_i && stb_i && !st_r.ack;
	assign wr = req && we_i;
	assign timer_done = (st_r.elapsed_ms >= st_r.delay_ms);

	always_comb begin
		st_nxt = st_r;
		ev = '0;
		ev_clr = '0;
		w = 32'h0000_0000;
		ef_lo = EF_ZC_STEP_MIN_STD;
		ef_hi = EF_ZC_MAX_STD;
		st_nxt.ack = req;

		// Sequence: start, timing, trip, release
		if (!st_r.ctrl[CTRL_ENABLE]) begin
			if (st_r.started) begin
				ev[EV_START_OFF] = 1'b1;
			end
			if (st_r.tripped) begin
				ev[EV_TRIP_OFF] = 1'b1;
			end
			st_nxt.started = 1'b0;
			st_nxt.tripped = 1'b0;
			st_nxt.elapsed_ms = 8'h00;
		end else if (!st_r.started) begin
			if (any_start) begin
				st_nxt.started = 1'b1;
				st_nxt.elapsed_ms = 8'h00;
				ev[EV_START_ON] = 1'b1;
				st_nxt.start_cnt = st_r.start_cnt + CNT_W'(1);
			end
		end else if (do_release) begin
			st_nxt.started = 1'b0;
			st_nxt.tripped = 1'b0;
			st_nxt.elapsed_ms = 8'h00;
			ev[EV_START_OFF] = 1'b1;
			ev[EV_TRIP_OFF] = st_r.tripped;
		end else if (!block_i) begin
			if (timer_done && !st_r.tripped) begin
				st_nxt.tripped = 1'b1;
				ev[EV_TRIP_ON] = 1'b1;
				st_nxt.trip_cnt = st_r.trip_cnt + CNT_W'(1);
			end else if (ms_tick && !timer_done) begin
				st_nxt.elapsed_ms = st_r.elapsed_ms + 8'h01;
			end
		end

		// Event enables gate logging
		ev = ev & {st_r.ctrl[CTRL_EV_TRIP_OFF], st_r.ctrl[CTRL_EV_TRIP_ON],
			st_r.ctrl[CTRL_EV_START_OFF], st_r.ctrl[CTRL_EV_START_ON]};

		// Register writes
		if (wr) begin
			case (adr_i)
				REG_CTRL: begin
					w = wmask(st_r.ctrl, dat_i, sel_i);
					st_nxt.ctrl = w;
					st_nxt.ctrl[CTRL_CLR_START] = 1'b0;
					st_nxt.ctrl[CTRL_CLR_TRIP] = 1'b0;
					if (w[CTRL_CLR_START]) begin
						st_nxt.start_cnt = '0;
					end
					if (w[CTRL_CLR_TRIP]) begin
						st_nxt.trip_cnt = '0;
					end
				end
				REG_COND_SEL: begin
					for (int i = 0; i < NUM_COND; i++) begin
						if (sel_i[i]) begin
							st_nxt.cond_sel[i*SRC_W +: 8] = dat_i[i*8 +: 8];
						end
					end
				end
				REG_RELEASE: st_nxt.release_cfg = wmask(st_r.release_cfg, dat_i, sel_i);
				REG_DELAY: begin
					if (sel_i[0]) begin
						st_nxt.delay_ms = clamp_delay(dat_i[7:0]);
					end
				end
				REG_PH_ZC: begin
					w = wmask({16'h0000, st_r.ph_zc}, dat_i, sel_i);
					st_nxt.ph_zc = clamp16(w[15:0], PH_ZC_MIN, PH_ZC_MAX);
				end
				REG_EF_ZC: begin
					if (st_r.ef_src == EF_SRC_CORE) begin
						ef_lo = EF_ZC_MIN_CORE;
					end else if (st_r.ef_src == EF_SRC_CALC) begin
						ef_hi = EF_ZC_MAX_CALC;
					end
					w = wmask({16'h0000, st_r.ef_zc}, dat_i, sel_i);
					st_nxt.ef_zc = clamp16(w[15:0], ef_lo, ef_hi);
				end
				REG_EF_SRC: begin
					if (sel_i[0]) begin
						st_nxt.ef_src = dat_i[1:0];
					end
				end
				REG_IRQ_STAT: begin
					if (sel_i[0]) begin
						ev_clr = dat_i[EV_W-1:0];
					end
				end
				REG_IRQ_MASK: begin
					if (sel_i[0]) begin
						st_nxt.irq_mask = dat_i[EV_W-1:0];
					end
				end
				default: ;
			endcase
		end
		// New events win over a clear in the same cycle
		st_nxt.irq_stat = (st_r.irq_stat & ~ev_clr) | ev;

		// Register reads
		st_nxt.rdata = 32'h0000_0000;
		if (req && !we_i) begin
			case (adr_i)
				REG_CTRL: st_nxt.rdata = st_r.ctrl;
				REG_COND_SEL: begin
					for (int i = 0; i < NUM_COND; i++) begin
						st_nxt.rdata[i*8 +: 8] = st_r.cond_sel[i*SRC_W +: 8];
					end
				end
				REG_RELEASE: st_nxt.rdata = st_r.release_cfg;
				REG_DELAY: st_nxt.rdata = {24'h000000, st_r.delay_ms};
				REG_PH_ZC: st_nxt.rdata = {16'h0000, st_r.ph_zc};
				REG_EF_ZC: st_nxt.rdata = {16'h0000, st_r.ef_zc};
				REG_EF_SRC: st_nxt.rdata = {30'h00000000, st_r.ef_src};
				REG_STATUS: st_nxt.rdata = {29'h00000000, block_i, st_r.tripped, st_r.started};
				REG_IRQ_STAT: st_nxt.rdata = {28'h0000000, st_r.irq_stat};
				REG_IRQ_MASK: st_nxt.rdata = {28'h0000000, st_r.irq_mask};
				REG_START_CNT: st_nxt.rdata = 32'(st_r.start_cnt);
				REG_TRIP_CNT: st_nxt.rdata = 32'(st_r.trip_cnt);
				default: st_nxt.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '0;
			st_r.ctrl <= CTRL_RST;
			st_r.release_cfg <= RELEASE_RST;
			st_r.delay_ms <= DELAY_RST;
			st_r.ph_zc <= PH_ZC_RST;
			st_r.ef_zc <= EF_ZC_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Start and trip outputs forced inactive while blocked
	assign start_o = st_r.started && !block_i;
	assign trip_o = st_r.tripped && !block_i;
	assign irq_o = |(st_r.irq_stat & st_r.irq_mask);
	assign ack_o = st_r.ack;
	assign dat_o = st_r.rdata;
endmodule : breaker_failure_stage

/* File: testbench/bf_field_model.sv */
// Far side model: protection stage starts, breaker status and measured currents
`timescale 1ns/1ps
module bf_field_model
	import bf_pkg::*;
#(
	parameter int DROP = 4
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Commands from the bench
	input wire logic [NUM_COND-1:0] fault_i,
	input wire logic [NUM_COND-1:0] open_i,
	input wire logic [15:0] amps_i,
	// Toward the stage
	output logic [SRC_W-1:0] start_src_o [NUM_COND],
	output logic [NUM_COND-1:0] cb_open_o,
	output logic [15:0] phase_cur_o [3],
	output logic [15:0] ef_cur_o
);
	logic [DROP-1:0] hold_r [NUM_COND];
	// A stage start lingers for its own reset time after the fault clears
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < NUM_COND; i++) begin
			hold_r[i] <= rst_i ? '0 : {hold_r[i][DROP-2:0], fault_i[i]};
		end
	end
	always_comb begin
		for (int i = 0; i < NUM_COND; i++) begin
			start_src_o[i] = {31'h0, fault_i[i] | (|hold_r[i])};
		end
	end
	assign cb_open_o = open_i;
	assign phase_cur_o = '{amps_i, amps_i, amps_i};
	assign ef_cur_o = amps_i;
endmodule : bf_field_model

/* File: testbench/bf_monitor.sv */
// Port checker for the breaker failure stage
`timescale 1ns/1ps
module bf_monitor
	import bf_pkg::*;
#(
	parameter int MS_DIV = MS_CYCLES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// Stage
	input wire logic [SRC_W-1:0] start_src_i [NUM_COND],
	input wire logic block_i,
	input wire logic start_o,
	input wire logic trip_o
);
	localparam int TMIN = 39 * MS_DIV;
	localparam int TMAX = 201 * MS_DIV + 4;
	logic [31:0] run_r;
	logic [31:0] run_nxt;
	logic any_src;
	assign any_src = |{start_src_i[0][7:0], start_src_i[1][7:0], start_src_i[2][7:0],
		start_src_i[3][7:0]};
	// Cycles shown started, held while blocked
	always_comb begin
		run_nxt = run_r;
		if (!start_o && !block_i) begin
			run_nxt = '0;
		end else if (start_o) begin
			run_nxt = run_r + 32'h0000_0001;
		end
	end
	always_ff @(posedge clk_i) begin
		run_r <= rst_i ? '0 : run_nxt;
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking mon_clk @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_ack;
		ack_o ##1 !ack_o;
	endsequence
	AST_ACK_REQ: assert property (s_req |=> s_ack)
		else $error("ack not one cycle after request");
	AST_DAT_IDLE: assert property (!ack_o |-> dat_o == 32'h0)
		else $error("read data not zero outside ack");
	AST_BLOCK_OUT: assert property (block_i |-> !start_o && !trip_o)
		else $error("output active while blocked");
	AST_TRIP_START: assert property (trip_o |-> start_o)
		else $error("trip without start");
	AST_START_CAUSE: assert property ($rose(start_o) && !$past(block_i) |-> $past(any_src))
		else $error("start without a source");
	AST_TRIP_MIN: assert property ($rose(trip_o) |-> run_r >= TMIN)
		else $error("trip before the shortest delay");
	AST_TRIP_MAX: assert property (start_o && !trip_o |-> run_r <= TMAX)
		else $error("no trip after the longest delay");
	AST_RELEASE: assert property ($fell(start_o) && !block_i && !$past(block_i) |-> (!trip_o) [*8])
		else $error("trip after release");
endmodule : bf_monitor

bind breaker_failure_stage bf_monitor #(.MS_DIV(MS_DIV)) u_mon (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .start_src_i(start_src_i),
	.block_i(block_i), .start_o(start_o), .trip_o(trip_o));

/* File: testbench/test_breaker_failure_stage.sv */
// Self-checking bench for the breaker failure stage
`timescale 1ns/1ps
module test_breaker_failure_stage import bf_pkg::*;;
	localparam int DIV = 10;
	logic clk_i, rst_i, cyc, stb, we, ack, blk, start_o, trip_o, irq_o;
	logic [7:0] adr;
	logic [31:0] dat, rdat, q;
	logic [3:0] fault, open_c, cb;
	logic [15:0] amps, ef;
	logic [15:0] ph [3];
	logic [SRC_W-1:0] src [NUM_COND];
	int err_count, tests_run, n;

	breaker_failure_stage #(.MS_DIV(DIV), .CNT_W(16)) dut (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat),
		.dat_o(rdat), .ack_o(ack), .start_src_i(src), .cb_open_i(cb), .phase_cur_i(ph),
		.ef_cur_i(ef), .block_i(blk), .start_o(start_o), .trip_o(trip_o), .irq_o(irq_o));
	bf_field_model #(.DROP(4)) far (.clk_i(clk_i), .rst_i(rst_i), .fault_i(fault),
		.open_i(open_c), .amps_i(amps), .start_src_o(src), .cb_open_o(cb),
		.phase_cur_o(ph), .ef_cur_o(ef));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 20);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (k >= 20) err_count++;
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
		wb(1'b0, a, 32'h0);
		chk(s, e, q);
	endtask : rd
	task automatic wait_out(input logic tr, input logic v);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (((tr ? trip_o : start_o) !== v) && n < 3000);
		chk(tr ? "trip" : "start", 32'(v), 32'(tr ? trip_o : start_o));
	endtask : wait_out
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	initial begin
		repeat (40000) @(posedge clk_i);
		err_count++;
		close_out();
	end
	initial begin
		{cyc, stb, we, blk, adr, dat, fault, open_c} = '0;
		rst_i = 1'b1;
		amps = 16'h0100;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(REG_CTRL, CTRL_RST, "ctrl");
		rd(REG_DELAY, {24'h0, DELAY_RST}, "delay");
		rd(REG_PH_ZC, {16'h0, PH_ZC_RST}, "ph_zc");
		rd(8'hFC, 32'h0, "unmapped");
		@(posedge clk_i);
		fault <= 4'h1;
		repeat (30) @(posedge clk_i);
		chk("start while disabled", 32'h0, 32'(start_o));
		fault <= 4'h0;
		$display("test reset done");
		wb(1'b1, REG_DELAY, 32'h0);
		rd(REG_DELAY, 32'h28, "delay low clamp");
		wb(1'b1, REG_DELAY, 32'hFF);
		rd(REG_DELAY, 32'hC8, "delay high clamp");
		wb(1'b1, REG_DELAY, 32'h28);
		wb(1'b1, REG_PH_ZC, 32'h0);
		rd(REG_PH_ZC, 32'h5, "ph_zc low clamp");
		wb(1'b1, REG_PH_ZC, 32'hFF);
		rd(REG_PH_ZC, 32'h14, "ph_zc high clamp");
		wb(1'b1, REG_EF_SRC, 32'h1);
		wb(1'b1, REG_EF_ZC, 32'h0);
		rd(REG_EF_ZC, 32'h32, "ef_zc core low clamp");
		wb(1'b1, REG_EF_SRC, 32'h2);
		wb(1'b1, REG_EF_ZC, 32'hFFFF);
		rd(REG_EF_ZC, 32'h4E20, "ef_zc calc high clamp");
		wb(1'b1, REG_EF_SRC, 32'h0);
		wb(1'b1, REG_EF_ZC, 32'hFFFF);
		rd(REG_EF_ZC, 32'h1F40, "ef_zc std high clamp");
		wb(1'b1, REG_EF_ZC, 32'h1);
		rd(REG_EF_ZC, 32'h5, "ef_zc std low clamp");
		$display("test delay done");
		wb(1'b1, REG_CTRL, 32'h1F);
		wb(1'b1, REG_IRQ_MASK, 32'hF);
		wb(1'b1, REG_RELEASE, 32'h0);
		for (int i = 0; i < NUM_COND; i++) begin
			wb(1'b1, REG_COND_SEL, 32'h1 << (8 * i));
			fault <= 4'h1 << i;
			wait_out(1'b0, 1'b1);
			repeat (8) @(posedge clk_i);
			chk("start held by source", 32'h1, 32'(start_o));
			fault <= 4'h0;
			wait_out(1'b0, 1'b0);
		end
		rd(REG_START_CNT, 32'h4, "start count");
		$display("test selectors done");
		wb(1'b1, REG_IRQ_STAT, 32'hF);
		rd(REG_IRQ_STAT, 32'h0, "irq cleared");
		chk("irq low", 32'h0, 32'(irq_o));
		wb(1'b1, REG_COND_SEL, 32'h1);
		wb(1'b1, REG_RELEASE, 32'h1);
		fault <= 4'h1;
		wait_out(1'b0, 1'b1);
		wait_out(1'b1, 1'b1);
		chk("trip delay", 32'h1, 32'(n >= 38 * DIV && n <= 42 * DIV));
		rd(REG_IRQ_STAT, 32'h5, "events on");
		chk("irq high", 32'h1, 32'(irq_o));
		wb(1'b1, REG_IRQ_MASK, 32'h0);
		@(posedge clk_i);
		chk("irq masked", 32'h0, 32'(irq_o));
		fault <= 4'h0;
		wait_out(1'b0, 1'b0);
		chk("trip released", 32'h0, 32'(trip_o));
		rd(REG_IRQ_STAT, 32'hF, "events off");
		rd(REG_TRIP_CNT, 32'h1, "trip count");
		$display("test trip done");
		fault <= 4'h1;
		wait_out(1'b0, 1'b1);
		repeat (20 * DIV) @(posedge clk_i);
		blk <= 1'b1;
		repeat (60 * DIV) @(posedge clk_i);
		chk("start blocked", 32'h0, 32'(start_o | trip_o));
		rd(REG_STATUS, 32'h5, "status blocked");
		blk <= 1'b0;
		wait_out(1'b1, 1'b1);
		chk("resumed delay", 32'h1, 32'(n >= 15 * DIV && n <= 25 * DIV));
		fault <= 4'h0;
		wait_out(1'b0, 1'b0);
		$display("test block done");
		wb(1'b1, REG_RELEASE, 32'h6);
		fault <= 4'h1;
		wait_out(1'b0, 1'b1);
		fault <= 4'h0;
		amps <= 16'h0;
		repeat (50) @(posedge clk_i);
		chk("zero current alone", 32'h1, 32'(start_o));
		amps <= 16'h0100;
		open_c <= 4'h1;
		repeat (50) @(posedge clk_i);
		chk("breaker open alone", 32'h1, 32'(start_o));
		amps <= 16'h0;
		wait_out(1'b0, 1'b0);
		wb(1'b1, REG_CTRL, 32'h31F);
		rd(REG_START_CNT, 32'h0, "start count clear");
		rd(REG_TRIP_CNT, 32'h0, "trip count clear");
		rd(REG_CTRL, 32'h1F, "clear bits self clear");
		$display("test release done");
		close_out();
	end
endmodule : test_breaker_failure_stage
